//--- include/spi_port_pkg.sv
// Purpose: shared constants for the serial port block
// Assumes: 32-bit register bus, byte addresses
// Notes: one-hot state codes are written out
package spi_port_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [31:0] WIN_LO = 32'h4000_1820;
	localparam logic [31:0] WIN_HI = 32'h4000_1BFF;
	localparam logic [31:0] CFG_ADDR = 32'h4000_1820;
	localparam logic [31:0] DATA_ADDR = 32'h4000_1824;
	localparam logic [31:0] CLKCFG_ADDR = 32'h4000_1828;
	localparam logic [31:0] STAT_ADDR = 32'h4000_182C;
	localparam logic [31:0] IRQ_CLR_ADDR = 32'h4000_1830;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CFG_SAMPLE_BIT = 5;
	localparam int CFG_SSEL_BIT = 6;
	localparam int CFG_EN_BIT = 7;
	localparam int CLK_CPOL_BIT = 0;
	localparam int CLK_CPHA_BIT = 1;
	localparam int CLK_DIV_LSB = 2;
	localparam int CLK_DIV_W = 6;
	localparam int ST_RX_OVERRUN_FLAG_BIT = 0;
	localparam int ST_RX_FULL_FLAG_BIT = 1;
	localparam int ST_TX_EMPTY_FLAG_BIT = 2;
	localparam int ST_WRITE_COLLISION_FLAG_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_CLRTX_BIT = 7;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] CFG_RESET = 8'h40;
	localparam logic [7:0] CLKCFG_RESET = 8'h07;
	localparam logic [3:0] FLAGS_RESET = 4'h4;
	localparam logic [3:0] EDGE_LAST = 4'hF;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_XFER = 2'b10
	} xfer_state_e;
endpackage : spi_port_pkg

//--- verilog/spi_clk_div.sv
// Purpose: half-period tick for the serial clock
// Assumes: div is stable while run is high
// Notes: one tick every div+1 cycles, so a full period is 2*(div+1)
`timescale 1ns/10ps
`default_nettype none
module spi_clk_div (
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [5:0] div,
	output logic tick
);
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q + 6'h01;
		if (!run || cnt_q == div) begin
			cnt_d = 6'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// restarts from zero each frame so the first edge is a full half period late
	assign tick = run && (cnt_q == div);
endmodule : spi_clk_div
`default_nettype wire

//--- verilog/spi_master_port.sv
// Purpose: register-mapped serial master with buffers and interrupt
// Assumes: single clock, bus strobes one cycle long, never together
// Notes: transfers are 8 bits, msb first
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - config bits 0-3 enable four interrupts
// - bit 5 picks miso capture edge
// - bit 6 drives slave select, resets high
// - bit 7 enables port, resets off
// - unassigned bits read zero, ignore writes
// - data write fills tx buffer, clears empty
// - data read returns rx buffer, clears full
// - write into full tx buffer collides
// - serial period is 2*(divider+1) cycles
// - polarity sets idle, phase picks edge
// - byte into full rx buffer overruns
// - tx empty sets on load, resets high
module spi_master_port (
	input wire logic clk,
	input wire logic srst,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	output logic sck,
	output logic mosi,
	input wire logic miso,
	output logic ssel
);
	// ************************************************************
	// state
	// ************************************************************
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] clkcfg_q, clkcfg_d;
	logic [3:0] flags_q, flags_d;
	logic [7:0] tx_buf_q, tx_buf_d;
	logic [7:0] rx_buf_q, rx_buf_d;
	logic [31:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	spi_port_pkg::xfer_state_e state_q, state_d;
	logic [7:0] tx_sh_q, tx_sh_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic [3:0] edge_q, edge_d;
	logic sck_q, sck_d;
	logic mosi_q, mosi_d;
	logic tick;
	logic load, arrive, sample_now, shift_now;
	logic [7:0] rx_next, rx_byte;
	logic wr_cfg, wr_data, wr_clk, wr_stat, wr_clr, rd_data, rd_stat;
	logic en, cpol, cpha;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	assign en = cfg_q[spi_port_pkg::CFG_EN_BIT];
	assign cpol = clkcfg_q[spi_port_pkg::CLK_CPOL_BIT];
	assign cpha = clkcfg_q[spi_port_pkg::CLK_CPHA_BIT];

	// ************************************************************
	// bus decode
	// ************************************************************
	always_comb begin
		wr_cfg = 1'b0;
		wr_data = 1'b0;
		wr_clk = 1'b0;
		wr_stat = 1'b0;
		wr_clr = 1'b0;
		rd_data = 1'b0;
		rd_stat = 1'b0;
		// exact match only: stray addresses inside the window fall through unanswered
		if (hit(addr, spi_port_pkg::CFG_ADDR)) begin
			wr_cfg = wr;
		end else if (hit(addr, spi_port_pkg::DATA_ADDR)) begin
			wr_data = wr;
			rd_data = rd;
		end else if (hit(addr, spi_port_pkg::CLKCFG_ADDR)) begin
			wr_clk = wr;
		end else if (hit(addr, spi_port_pkg::STAT_ADDR)) begin
			wr_stat = wr;
			rd_stat = rd;
		end else if (hit(addr, spi_port_pkg::IRQ_CLR_ADDR)) begin
			wr_clr = wr;
		end
	end

	spi_clk_div u_div (
		.clk(clk),
		.srst(srst),
		.run(en && state_q == spi_port_pkg::ST_XFER),
		.div(clkcfg_q[spi_port_pkg::CLK_DIV_LSB +: spi_port_pkg::CLK_DIV_W]),
		.tick(tick)
	);

	// ************************************************************
	// shift engine
	// ************************************************************
	always_comb begin
		state_d = state_q;
		tx_sh_d = tx_sh_q;
		rx_sh_d = rx_sh_q;
		edge_d = edge_q;
		sck_d = sck_q;
		mosi_d = mosi_q;
		load = 1'b0;
		arrive = 1'b0;
		// even edges lead; phase picks which parity samples
		sample_now = tick && (edge_q[0] == cpha);
		shift_now = tick && (edge_q[0] != cpha);
		rx_next = {rx_sh_q[6:0], miso};
		// the last edge is not always a capture edge, so the byte may already be whole
		rx_byte = (cfg_q[spi_port_pkg::CFG_SAMPLE_BIT] ? shift_now : sample_now) ? rx_next : rx_sh_q;
		case (state_q)
			spi_port_pkg::ST_IDLE: begin
				sck_d = cpol;
				edge_d = 4'h0;
				// a frame starts one cycle after the buffer fills, which costs one idle cycle
				if (en && !flags_q[spi_port_pkg::ST_TX_EMPTY_FLAG_BIT]) begin
					load = 1'b1;
					state_d = spi_port_pkg::ST_XFER;
					mosi_d = tx_buf_q[7];
					tx_sh_d = cpha ? tx_buf_q : {tx_buf_q[6:0], 1'b0};
				end
			end
			spi_port_pkg::ST_XFER: begin
				if (!en) begin
					// abort: buffers are left as they are
					state_d = spi_port_pkg::ST_IDLE;
					sck_d = cpol;
				end else if (tick) begin
					sck_d = !sck_q;
					edge_d = edge_q + 4'h1;
					if (cfg_q[spi_port_pkg::CFG_SAMPLE_BIT] ? shift_now : sample_now) begin
						rx_sh_d = rx_next;
					end
					if (shift_now) begin
						mosi_d = tx_sh_q[7];
						tx_sh_d = {tx_sh_q[6:0], 1'b0};
					end
					if (edge_q == spi_port_pkg::EDGE_LAST) begin
						arrive = 1'b1;
						state_d = spi_port_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				state_d = spi_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= spi_port_pkg::ST_IDLE;
			tx_sh_q <= 8'h00;
			rx_sh_q <= 8'h00;
			edge_q <= 4'h0;
			sck_q <= spi_port_pkg::CLKCFG_RESET[spi_port_pkg::CLK_CPOL_BIT];
			mosi_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tx_sh_q <= tx_sh_d;
			rx_sh_q <= rx_sh_d;
			edge_q <= edge_d;
			sck_q <= sck_d;
			mosi_q <= mosi_d;
		end
	end

	// ************************************************************
	// registers and flags
	// ************************************************************
	always_comb begin
		cfg_d = cfg_q;
		clkcfg_d = clkcfg_q;
		flags_d = flags_q;
		tx_buf_d = tx_buf_q;
		rx_buf_d = rx_buf_q;
		rdata_d = 32'h0000_0000;
		// clears first so a same-cycle set wins
		if (rd_stat) begin
			flags_d[spi_port_pkg::ST_RX_OVERRUN_FLAG_BIT] = 1'b0;
			flags_d[spi_port_pkg::ST_WRITE_COLLISION_FLAG_BIT] = 1'b0;
		end
		if (wr_clr) begin
			flags_d[spi_port_pkg::ST_RX_OVERRUN_FLAG_BIT] = flags_d[spi_port_pkg::ST_RX_OVERRUN_FLAG_BIT] & ~wdata[spi_port_pkg::ST_RX_OVERRUN_FLAG_BIT];
			flags_d[spi_port_pkg::ST_WRITE_COLLISION_FLAG_BIT] = flags_d[spi_port_pkg::ST_WRITE_COLLISION_FLAG_BIT] & ~wdata[spi_port_pkg::ST_WRITE_COLLISION_FLAG_BIT];
		end
		if (rd_data) begin
			flags_d[spi_port_pkg::ST_RX_FULL_FLAG_BIT] = 1'b0;
		end
		if (wr_cfg) begin
			cfg_d = {wdata[7:5], 1'b0, wdata[3:0]};
		end
		if (wr_clk) begin
			clkcfg_d = wdata[7:0];
		end
		if (load || (wr_stat && wdata[spi_port_pkg::ST_CLRTX_BIT])) begin
			flags_d[spi_port_pkg::ST_TX_EMPTY_FLAG_BIT] = 1'b1;
		end
		if (wr_data) begin
			// a load in this cycle frees the buffer in time
			if (flags_q[spi_port_pkg::ST_TX_EMPTY_FLAG_BIT] || load) begin
				tx_buf_d = wdata[7:0];
				flags_d[spi_port_pkg::ST_TX_EMPTY_FLAG_BIT] = 1'b0;
			end else begin
				flags_d[spi_port_pkg::ST_WRITE_COLLISION_FLAG_BIT] = 1'b1;
			end
		end
		if (arrive) begin
			if (!flags_q[spi_port_pkg::ST_RX_FULL_FLAG_BIT] || rd_data) begin
				rx_buf_d = rx_byte;
				flags_d[spi_port_pkg::ST_RX_FULL_FLAG_BIT] = 1'b1;
			end else begin
				flags_d[spi_port_pkg::ST_RX_OVERRUN_FLAG_BIT] = 1'b1;
			end
		end
		if (rd_stat) begin
			rdata_d[3:0] = flags_q;
			rdata_d[spi_port_pkg::ST_BUSY_BIT] = (state_q == spi_port_pkg::ST_XFER);
		end else if (rd && hit(addr, spi_port_pkg::CFG_ADDR)) begin
			rdata_d[7:0] = cfg_q;
		end else if (rd_data) begin
			rdata_d[7:0] = rx_buf_q;
		end else if (rd && hit(addr, spi_port_pkg::CLKCFG_ADDR)) begin
			rdata_d[7:0] = clkcfg_q;
		end
		irq_d = |(flags_d & cfg_d[3:0]);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_q <= spi_port_pkg::CFG_RESET;
			clkcfg_q <= spi_port_pkg::CLKCFG_RESET;
			flags_q <= spi_port_pkg::FLAGS_RESET;
			tx_buf_q <= 8'h00;
			rx_buf_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			irq_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			clkcfg_q <= clkcfg_d;
			flags_q <= flags_d;
			tx_buf_q <= tx_buf_d;
			rx_buf_q <= rx_buf_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign sck = sck_q;
	assign mosi = mosi_q;
	assign ssel = cfg_q[spi_port_pkg::CFG_SSEL_BIT];

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	irq_or_a: assert property (##1 irq == |(flags_q & cfg_q[3:0]))
		else $error("irq not the OR of enabled flags");
	ssel_write_a: assert property (wr_cfg |=> ssel == $past(wdata[6]))
		else $error("slave select did not follow config write");
	sck_idle_a: assert property (!en |=> sck == $past(cpol))
		else $error("serial clock not idle while disabled");
	tx_accept_a: assert property (wr_data && flags_q[2] |=> !flags_q[2] && tx_buf_q == $past(wdata[7:0]))
		else $error("data write not taken into tx buffer");
	tx_collide_a: assert property (wr_data && !flags_q[2] && !load |=> flags_q[3] && $stable(tx_buf_q))
		else $error("collision not flagged or buffer changed");
	rx_clear_a: assert property (rd_data && !arrive |=> !flags_q[1] && rdata[7:0] == $past(rx_buf_q))
		else $error("data read did not return buffer or clear full");
	rx_overrun_a: assert property (arrive && flags_q[1] && !rd_data |=> flags_q[0] && $stable(rx_buf_q))
		else $error("overrun not flagged or buffer overwritten");
	load_empty_a: assert property (load && !wr_data |=> flags_q[2] && state_q == spi_port_pkg::ST_XFER)
		else $error("load did not set tx empty");
	rsvd_zero_a: assert property (rd |=> rdata[31:8] == 24'h000000)
		else $error("reserved read bits not zero");
	sck_hold_a: assert property (state_q == spi_port_pkg::ST_XFER && en && !tick |=> $stable(sck))
		else $error("serial clock moved between divider ticks");
	sck_rest_a: assert property (state_q == spi_port_pkg::ST_IDLE |=> sck == $past(cpol))
		else $error("serial clock not at polarity level while idle");
	mosi_load_a: assert property (load |=> mosi == $past(tx_buf_q[7]))
		else $error("first data bit not shown at load");
	rx_fill_a: assert property (arrive && !flags_q[1] |=> flags_q[1])
		else $error("rx full not set on arrival");
	off_idle_a: assert property (!en |=> state_q == spi_port_pkg::ST_IDLE)
		else $error("engine not idle while disabled");

	xfer_done_c: cover property (arrive && !flags_q[1]);
	late_capture_c: cover property (arrive && cfg_q[spi_port_pkg::CFG_SAMPLE_BIT]);
	phase_one_c: cover property (arrive && cpha);
	collide_c: cover property (wr_data && !flags_q[2] && !load);
	overrun_c: cover property (arrive && flags_q[1]);
endmodule : spi_master_port
`default_nettype wire

//--- verification/spi_slave_model.sv
// Purpose: behavioural serial slave at the far side of the port
// Assumes: polarity equal to phase (modes 0 and 3), slave selected while ssel is low
// Notes: answers with reply, msb first; counts whole frames
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
	input wire logic sck,
	input wire logic ssel,
	input wire logic mosi,
	input wire logic [7:0] reply,
	output logic miso = 1'b1,
	output logic [7:0] got = 8'h00,
	output int frames = 0
);
	// ****************************************
	// shift logic
	// ****************************************
	logic [7:0] sh_out = 8'h00;
	logic [7:0] sh_in = 8'h00;
	logic ssel_was = 1'b1;
	logic sck_was = 1'b1;
	int bits = 0;

	// one process owns every variable; edges are told apart by the last seen levels
	always @(ssel, sck) begin
		if (ssel !== ssel_was) begin
			if (!ssel) begin
				sh_out = reply;
				miso = reply[7];
				bits = 0;
			end else begin
				// released line shows the inverse, not a stale bit
				miso = ~miso;
			end
		end else if (!ssel && sck !== sck_was) begin
			if (sck) begin
				// modes 0 and 3 both sample on the rising edge
				sh_in = {sh_in[6:0], mosi};
				bits++;
				if (bits == 8) begin
					got = sh_in;
					frames++;
					bits = 0;
				end
			end else begin
				sh_out = (bits == 0) ? reply : {sh_out[6:0], 1'b0};
				miso = sh_out[7];
			end
		end
		ssel_was = ssel;
		sck_was = sck;
	end
endmodule : spi_slave_model
`default_nettype wire

//--- verification/spi_master_port_test.sv
// Purpose: register-level test of the serial master port
// Assumes: slave model in modes 0 and 3, divider 2
// Notes: frame waits are fixed since frame length is fixed
`timescale 1ns/10ps
`default_nettype none
module spi_master_port_test;
	localparam logic [31:0] CFG = spi_port_pkg::CFG_ADDR;
	localparam logic [31:0] DAT = spi_port_pkg::DATA_ADDR;
	localparam logic [31:0] CLK = spi_port_pkg::CLKCFG_ADDR;
	localparam logic [31:0] STA = spi_port_pkg::STAT_ADDR;
	localparam logic [31:0] CLR = spi_port_pkg::IRQ_CLR_ADDR;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] addr = 32'h0000_0000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [7:0] reply = 8'h3C;
	logic [31:0] rdata;
	logic irq, sck, mosi, miso, ssel;
	logic [7:0] got;
	int frames;
	int err_count = 0;
	int n_tests = 0;
	int k;

	always #25 clk = ~clk;

	spi_master_port i_spi_master_port (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .sck(sck), .mosi(mosi), .miso(miso), .ssel(ssel));
	spi_slave_model i_spi_slave_model (.sck(sck), .ssel(ssel), .mosi(mosi), .reply(reply), .miso(miso),
		.got(got), .frames(frames));

	// ****************************************
	// tasks
	// ****************************************
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			$display("mismatch %s exp %h seen %h", n, e, s);
			err_count++;
		end
	endtask : chk

	task wr_reg(input logic [31:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task rd_chk(input string n, input logic [31:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(n, rdata, e);
	endtask : rd_chk

	task wait_sck(input logic lvl);
		while (sck !== lvl && k < 40) begin
			@(posedge clk);
			k++;
		end
	endtask : wait_sck

	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		test_done();
	end

	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd_chk("cfg reset", CFG, 32'h0000_0040);
		rd_chk("clk reset", CLK, 32'h0000_0007);
		rd_chk("stat reset", STA, 32'h0000_0004);
		rd_chk("data reset", DAT, 32'h0000_0000);
		rd_chk("clr reads zero", CLR, 32'h0000_0000);
		chk("ssel reset", ssel, 32'h0000_0001);
		chk("irq reset", irq, 32'h0000_0000);
		wr_reg(CFG, 32'hFFFF_FF3F);
		rd_chk("cfg bits", CFG, 32'h0000_002F);
		chk("ssel low", ssel, 32'h0000_0000);
		chk("irq empty", irq, 32'h0000_0001);
		wr_reg(CFG, 32'h0000_0040);
		wr_reg(CLK, 32'h0000_0008);
		rd_chk("clk cfg", CLK, 32'h0000_0008);
		chk("irq off", irq, 32'h0000_0000);
		// port still off, so nothing drains the first byte and the second collides
		wr_reg(DAT, 32'h0000_00A5);
		wr_reg(DAT, 32'h0000_0011);
		wr_reg(CFG, 32'h0000_0080);
		k = 0;
		wait_sck(1'b1);
		k = 0;
		wait_sck(1'b0);
		wait_sck(1'b1);
		chk("sck period", k, 32'h0000_0006);
		reply <= 8'hC3;
		repeat (60) @(posedge clk);
		chk("slave byte", got, 32'h0000_00A5);
		chk("frames", frames, 32'h0000_0001);
		rd_chk("stat frame", STA, 32'h0000_000E);
		rd_chk("stat cleared", STA, 32'h0000_0006);
		wr_reg(CFG, 32'h0000_0081);
		wr_reg(DAT, 32'h0000_0077);
		repeat (60) @(posedge clk);
		chk("slave byte 2", got, 32'h0000_0077);
		chk("irq overrun", irq, 32'h0000_0001);
		wr_reg(CFG, 32'h0000_0080);
		@(posedge clk);
		chk("irq masked", irq, 32'h0000_0000);
		wr_reg(CFG, 32'h0000_0081);
		@(posedge clk);
		chk("irq unmasked", irq, 32'h0000_0001);
		wr_reg(CLR, 32'h0000_0001);
		@(posedge clk);
		chk("irq clear", irq, 32'h0000_0000);
		rd_chk("stat full", STA, 32'h0000_0006);
		rd_chk("data kept", DAT, 32'h0000_003C);
		rd_chk("stat read", STA, 32'h0000_0004);
		// pull enable in mid-byte
		wr_reg(DAT, 32'h0000_0033);
		repeat (10) @(posedge clk);
		wr_reg(CFG, 32'h0000_0000);
		repeat (4) @(posedge clk);
		k = 0;
		repeat (12) begin
			@(posedge clk);
			if (sck !== 1'b0)
				k++;
		end
		chk("sck idle", k, 32'h0000_0000);
		rd_chk("no rx", STA, 32'h0000_0004);
		rd_chk("rx kept", DAT, 32'h0000_003C);
		// capture on the shift edge in mode 0; changed only while off
		wr_reg(CFG, 32'h0000_0060);
		wr_reg(CFG, 32'h0000_00A0);
		wr_reg(DAT, 32'h0000_005A);
		repeat (60) @(posedge clk);
		chk("slave byte 3", got, 32'h0000_005A);
		rd_chk("late capture", DAT, 32'h0000_00C3);
		// mode 3: polarity and phase rewritten only while off
		wr_reg(CFG, 32'h0000_0040);
		wr_reg(CLK, 32'h0000_000B);
		reply <= 8'h96;
		wr_reg(CFG, 32'h0000_0080);
		wr_reg(DAT, 32'h0000_00E1);
		repeat (60) @(posedge clk);
		chk("mode 3 byte", got, 32'h0000_00E1);
		chk("mode 3 idle", sck, 32'h0000_0001);
		rd_chk("mode 3 rx", DAT, 32'h0000_0096);
		test_done();
	end
endmodule : spi_master_port_test
`default_nettype wire
